// [hdl/bbs_pkg.sv]
// Constants for the branch, bit-set and bit-test-skip execute block.
// Assumes a core clock split into four phases per instruction cycle.
// Contract
// (RL1) Top five bits 1101_0 mean relative jump; low eleven bits are the offset.
// (RL2) Jump loads counter with incremented counter plus twice offset; no flag changes.
// (RL3) Jump takes two cycles; the second cycle does nothing in every phase.
// (RL4) Opcode 1000 with bit, access-select, address sets the chosen bit in one cycle.
// (RL5) Access-select 0 uses the access bank; 1 uses the bank select pointer.
// (RL6) Extended set with access-select 0 treats addresses up to 95 as indexed offsets.
// (RL7) Two bit tests: skip when bit low, skip when bit high.
// (RL8) A met skip discards the prefetched word and runs a no-operation instead.
// (RL9) Bit set is a read-modify-write within one cycle, other bits kept.
package bbs_pkg;
    localparam int PC_W = 21;
    localparam int ADDR_W = 12;
    localparam logic [4:0] OPC_JUMP = 5'h1a;        // 1101_0
    localparam logic [3:0] OPC_RAISE = 4'h8;        // 1000
    localparam logic [3:0] OPC_SKIP_LOW = 4'hb;     // 1011
    localparam logic [3:0] OPC_SKIP_HIGH = 4'ha;    // 1010
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;     // 95
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [3:0] {
        BBS_PH1 = 4'h1,
        BBS_PH2 = 4'h2,
        BBS_PH3 = 4'h4,
        BBS_PH4 = 4'h8
    } bbs_phase_e;
endpackage : bbs_pkg

// [hdl/bbs_addr_resolve.sv]
// Resolves an 8-bit file address and access-select bit to a data address.
// Assumes the bank pointer and index base are stable for the whole cycle.
`timescale 1ns/100ps
`default_nettype none
module bbs_addr_resolve
    import bbs_pkg::*;
(
    input wire logic [7:0] file_addr,
    input wire logic access_sel,
    input wire logic ext_set_enable,
    input wire logic [3:0] bank_select_pointer,
    input wire logic [ADDR_W-1:0] index_base,
    output logic [ADDR_W-1:0] data_addr
);
    // Bank pointer, indexed offset or access bank halves
    always_comb begin
        if (access_sel) begin
            data_addr = {bank_select_pointer, file_addr};    // [RL5]
        end else if (ext_set_enable && (file_addr <= INDEX_LIMIT)) begin
            data_addr = ADDR_W'(index_base + {4'h0, file_addr});    // [RL6]
        end else if (file_addr < ACCESS_SPLIT) begin
            data_addr = {4'h0, file_addr};    // [RL5]
        end else begin
            data_addr = {ACCESS_HIGH_BANK, file_addr};    // [RL5]
        end
    end
endmodule : bbs_addr_resolve
`default_nettype wire

// [hdl/bbs_exec.sv]
// Four-phase decode and execute for relative jump, bit raise and bit-test skip.
// One instruction cycle is four clocks; a jump or met skip flushes the next cycle.
// Assumes the fetch unit holds instr_word and pc_incr steady through phase one,
// and the register file answers rf_rdata combinationally from rf_addr.
// Condition flags live elsewhere and are never touched here.
`timescale 1ns/100ps
`default_nettype none
module bbs_exec
    import bbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic [PC_W-1:0] pc_incr,
    input wire logic ext_set_enable,
    input wire logic [3:0] bank_select_pointer,
    input wire logic [ADDR_W-1:0] index_base,
    input wire logic [7:0] rf_rdata,
    output logic [3:0] phase,
    output logic [ADDR_W-1:0] rf_addr,
    output logic [7:0] rf_wdata,
    output logic rf_we,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic discard_fetch
);
    bbs_phase_e phase_q;
    bbs_phase_e phase_d;
    logic [15:0] instr_q;
    logic [15:0] instr_d;
    logic [7:0] rdata_q;
    logic [ADDR_W-1:0] addr_d;
    logic [ADDR_W-1:0] rf_addr_q;
    logic [7:0] rf_wdata_q;
    logic rf_we_q;
    logic pc_load_q;
    logic [PC_W-1:0] pc_value_q;
    logic flush_q;
    logic skip_q;
    logic take;
    logic [10:0] word_offset;
    logic [2:0] held_bit_pos;
    logic [7:0] raise_data;
    logic is_jump;
    logic is_raise;
    logic is_skip_low;
    logic is_skip_high;
    logic test_bit;
    logic skip_met;

    // Bit position mask from the bbb field
    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction : bit_mask

    // Sign-extend the 11-bit offset and double it
    function automatic logic [PC_W-1:0] jump_target(input logic [PC_W-1:0] base, input logic [10:0] n);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-11){n[10]}}, n};
        jump_target = PC_W'(base + (ext << 1));
    endfunction : jump_target

    // Top nibble of a word against an opcode
    function automatic logic nibble_is(input logic [15:0] word, input logic [3:0] opc);
        nibble_is = (word[15:12] == opc);
    endfunction : nibble_is

    // Skip verdict of the two bit tests
    function automatic logic skip_wanted(input logic low_op, input logic high_op, input logic bit_val);
        skip_wanted = (low_op && !bit_val) || (high_op && bit_val);
    endfunction : skip_wanted

    // Operand fields of the incoming and the latched word
    assign word_offset = instr_word[10:0];
    assign held_bit_pos = instr_q[11:9];

    // Opcode decode of the latched word
    assign is_jump = (instr_q[15:11] == OPC_JUMP);    // [RL1]
    assign is_raise = nibble_is(instr_q, OPC_RAISE);    // [RL4]
    assign is_skip_low = nibble_is(instr_q, OPC_SKIP_LOW);    // [RL7]
    assign is_skip_high = nibble_is(instr_q, OPC_SKIP_HIGH);    // [RL7]
    assign test_bit = |(rdata_q & bit_mask(held_bit_pos));
    assign skip_met = skip_wanted(is_skip_low, is_skip_high, test_bit);    // [RL7]

    // Old register value with the chosen bit forced high
    assign raise_data = rdata_q | bit_mask(held_bit_pos);    // [RL9]

    // A word is taken at the end of phase one unless the cycle is flushed
    assign take = (phase_q == BBS_PH1) && !flush_q;

    // Registered outputs driven straight from their flops
    assign phase = phase_q;
    assign rf_addr = rf_addr_q;
    assign rf_wdata = rf_wdata_q;
    assign rf_we = rf_we_q;
    assign pc_load = pc_load_q;
    assign pc_value = pc_value_q;
    assign discard_fetch = flush_q;

    bbs_addr_resolve u_addr (
        .file_addr(instr_word[7:0]),
        .access_sel(instr_word[8]),
        .ext_set_enable(ext_set_enable),
        .bank_select_pointer(bank_select_pointer),
        .index_base(index_base),
        .data_addr(addr_d)
    );

    // Next phase of the four-clock ring
    always_comb begin
        case (phase_q)
            BBS_PH1: phase_d = BBS_PH2;
            BBS_PH2: phase_d = BBS_PH3;
            BBS_PH3: phase_d = BBS_PH4;
            BBS_PH4: phase_d = BBS_PH1;
            default: phase_d = BBS_PH1;
        endcase
    end

    // Phase register, four clocks per instruction cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_q <= BBS_PH1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // Next word: a no-operation stands in for a flushed one
    always_comb begin
        instr_d = instr_q;
        if (phase_q == BBS_PH1) begin
            if (flush_q) begin
                instr_d = NOP_WORD;    // [RL3] [RL8]
            end else begin
                instr_d = instr_word;
            end
        end
    end

    // Latched word for phases two to four
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            instr_q <= NOP_WORD;
        end else begin
            instr_q <= instr_d;
        end
    end

    // Data address, held from phase two to the next take
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rf_addr_q <= ADDR_RESET;
        end else if (take) begin
            rf_addr_q <= addr_d;    // [RL5] [RL6]
        end
    end

    // Jump target, held to the next take
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_value_q <= PC_RESET;
        end else if (take) begin
            pc_value_q <= jump_target(pc_incr, word_offset);    // [RL2]
        end
    end

    // Read register during phase two
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= DATA_RESET;
        end else if (phase_q == BBS_PH2) begin
            rdata_q <= rf_rdata;    // [RL9]
        end
    end

    // Write strobe, high through phase four of a bit raise
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rf_we_q <= 1'b0;
        end else begin
            rf_we_q <= (phase_q == BBS_PH3) && is_raise;    // [RL4]
        end
    end

    // Write data, set up at the end of phase three
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rf_wdata_q <= DATA_RESET;
        end else if (phase_q == BBS_PH3) begin
            rf_wdata_q <= raise_data;    // [RL9]
        end
    end

    // Counter load, high through phase four of a jump
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pc_load_q <= 1'b0;
        end else begin
            pc_load_q <= (phase_q == BBS_PH3) && is_jump;    // [RL2]
        end
    end

    // Skip verdict, kept until the flush marker takes it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            skip_q <= 1'b0;
        end else if (phase_q == BBS_PH3) begin
            skip_q <= skip_met;    // [RL7]
        end
    end

    // Flush marker for the following cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flush_q <= 1'b0;
        end else if (phase_q == BBS_PH4) begin
            flush_q <= is_jump || skip_q;    // [RL3] [RL8]
        end
    end
endmodule : bbs_exec
`default_nettype wire

// [tb/bbs_exec_asserts.sv]
// Checker for the jump, bit raise and bit-test skip execute block.
// Assumes it is bound to bbs_exec and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module bbs_exec_asserts
    import bbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] instr_word,
    input wire logic [PC_W-1:0] pc_incr,
    input wire logic ext_set_enable,
    input wire logic [3:0] bank_select_pointer,
    input wire logic [ADDR_W-1:0] index_base,
    input wire logic [7:0] rf_rdata,
    input wire logic [3:0] phase,
    input wire logic [ADDR_W-1:0] rf_addr,
    input wire logic [7:0] rf_wdata,
    input wire logic rf_we,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] pc_value,
    input wire logic discard_fetch
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [11:0] ea_q;
    logic [20:0] jt_q;
    logic [7:0] bm_q;
    wire [7:0] f = instr_word[7:0];
    wire tk = phase == 4'h1 && !discard_fetch;
    wire jmp = instr_word[15:11] == OPC_JUMP;
    wire rse = instr_word[15:12] == OPC_RAISE;
    wire tst = instr_word[15:13] == 3'b101;
    // Expected address, target and mask captured at each take
    always_ff @(posedge clk_sys) if (tk) begin
        ea_q <= instr_word[8] ? {bank_select_pointer, f} : ext_set_enable && f <= INDEX_LIMIT ? index_base + f
            : {{4{f > INDEX_LIMIT}}, f};
        jt_q <= pc_incr + {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
        bm_q <= 8'h01 << instr_word[11:9];
    end
    a_phase_ring: assert property (phase == 4'h1 |=> phase == 4'h2 ##1 phase == 4'h4 ##1 phase == 4'h8)
        else $error("phase sequence broken");
    a_jump_pc: assert property (tk && jmp |-> ##3 pc_load && pc_value == jt_q)
        else $error("jump target wrong");
    a_jump_flush: assert property (tk && jmp |-> ##4 discard_fetch [*4] ##1 !discard_fetch)
        else $error("jump second cycle wrong");
    a_flush_idle: assert property (discard_fetch |-> !rf_we && !pc_load)
        else $error("flushed cycle acted");
    a_raise_wr: assert property (tk && rse |-> ##3 rf_we && rf_wdata == ($past(rf_rdata, 2) | bm_q))
        else $error("bit raise write wrong");
    a_addr_map: assert property (tk && (rse || tst) |=> rf_addr == ea_q)
        else $error("data address wrong");
    a_skip_met: assert property (tk && tst ##1 (|(rf_rdata & bm_q)) != $past(instr_word[12]) |-> ##3 discard_fetch [*4])
        else $error("met skip not flushed");
    a_skip_pass: assert property (tk && tst ##1 (|(rf_rdata & bm_q)) == $past(instr_word[12]) |-> ##3 !discard_fetch)
        else $error("unmet skip flushed");
    c_jump: cover property (pc_load);
    c_raise: cover property (rf_we);
    c_flush: cover property (discard_fetch);
endmodule : bbs_exec_asserts
bind bbs_exec bbs_exec_asserts sva (.clk_sys, .rst, .instr_word, .pc_incr, .ext_set_enable, .bank_select_pointer,
    .index_base, .rf_rdata, .phase, .rf_addr, .rf_wdata, .rf_we, .pc_load, .pc_value, .discard_fetch);
`default_nettype wire

// [tb/bbs_rf_model.sv]
// Behavioural data register file facing the execute block.
// Assumes a combinational read and a write at the edge with rf_we.
`timescale 1ns/100ps
`default_nettype none
module bbs_rf_model
    import bbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [ADDR_W-1:0] rf_addr,
    input wire logic [7:0] rf_wdata,
    input wire logic rf_we,
    output logic [7:0] rf_rdata
);
    logic [7:0] mem [0:4095];
    // Varied preset contents
    initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h3c;
    // Read any time, write on the strobe
    assign rf_rdata = mem[rf_addr];
    always @(posedge clk_sys) if (rf_we) mem[rf_addr] <= rf_wdata;
endmodule : bbs_rf_model
`default_nettype wire

// [tb/tb_branch_bitset_skip_exec.sv]
// Top bench for the jump, bit raise and bit-test skip execute block.
// Assumes the register file model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_branch_bitset_skip_exec;
    logic clk_sys = 0, rst = 1, ext = 0, we, pl, df;
    logic [15:0] iw = 0;
    logic [20:0] pci = 0, pv;
    logic [11:0] ib = 0, ra;
    logic [7:0] rd, wd;
    logic [3:0] bsp = 0, ph;
    logic [31:0] seed = 32'h8c1062d0;
    logic [3:0] ops [4] = '{4'hd, 4'h8, 4'hb, 4'ha};
    logic [15:0] cw [7] = '{16'hd400, 16'hd3ff, 16'h8e5f, 16'h8060, 16'hb000, 16'ha000, 16'hd800};
    int err_count = 0, num_checks = 0, cyc = 0;
    bbs_exec uut (.clk_sys, .rst, .instr_word(iw), .pc_incr(pci), .ext_set_enable(ext), .bank_select_pointer(bsp),
        .index_base(ib), .rf_rdata(rd), .phase(ph), .rf_addr(ra), .rf_wdata(wd), .rf_we(we), .pc_load(pl),
        .pc_value(pv), .discard_fetch(df));
    bbs_rf_model rf (.clk_sys, .rf_addr(ra), .rf_wdata(wd), .rf_we(we), .rf_rdata(rd));
    initial forever #12.5 clk_sys = ~clk_sys;
    function logic [31:0] xs(input logic [31:0] s);
        xs = s ^ (s << 13);
        xs ^= xs >> 17;
        xs ^= xs << 5;
    endfunction : xs
    // Data address the bench expects
    function logic [11:0] ea(input logic [15:0] w);
        return w[8] ? {bsp, w[7:0]} : ext && w[7:0] < 8'h60 ? ib + w[7:0] : {{4{w[7:0] > 8'h5f}}, w[7:0]};
    endfunction : ea
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task summarize;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    // One instruction cycle, plus the flushed cycle when one is due
    task run(input logic [15:0] w);
        logic [7:0] old, m;
        logic [11:0] a;
        logic j, fl;
        seed = xs(seed);
        iw <= w;
        ext <= seed[0];
        bsp <= seed[4:1];
        ib <= seed[16:5];
        pci <= seed[31:11];
        repeat (3) @(posedge clk_sys);
        #1 a = ea(w);
        m = 8'h01 << w[11:9];
        old = rf.mem[a];
        j = w[15:11] == 5'h1a;
        fl = j || (w[15:13] == 3'b101 && ((old & m) != 0) != w[12]);
        chk("df", df, 0);
        chk("ph", ph, 4'h8);
        chk("pl", pl, j);
        chk("we", we, w[15:12] == 4'h8);
        if (j) chk("pv", pv, 21'(pci + {{9{w[10]}}, w[10:0], 1'b0}));
        if (w[15:12] == 4'h8) chk("wd", wd, old | m);
        if (w[15:12] == 4'h8 || w[15:13] == 3'b101) chk("ra", ra, a);
        @(posedge clk_sys);
        if (fl) begin
            iw <= {4'h8, seed[11:0]};
            repeat (3) @(posedge clk_sys);
            #1 chk("fl", df, 1);
            chk("qw", we, 0);
            @(posedge clk_sys);
        end
    endtask : run
    // Corner words first, then random ones
    initial begin
        repeat (19) @(posedge clk_sys);
        #1 chk("rst", {ph, we, pl, df, ra, wd}, {4'h1, 3'b000, 12'h000, 8'h00});
        chk("rpv", pv, 0);
        @(posedge clk_sys);
        rst <= 0;
        foreach (cw[i]) run(cw[i]);
        repeat (150) begin
            seed = xs(seed);
            run(seed[20] ? {ops[seed[22:21]], seed[11:0]} : seed[15:0]);
        end
        summarize();
    end
    // Cycle ceiling against a hang
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end
endmodule : tb_branch_bitset_skip_exec
`default_nettype wire
